// File: logic/mocr_pkg.sv
package mocr_pkg;

  // Register port addresses
  localparam logic [7:0] MOCR_ADDR_R2_OFFSET = 8'h72;
  localparam logic [7:0] MOCR_ADDR_CONFIG_TWO = 8'h73;

  // Power-on defaults
  localparam logic [7:0] MOCR_RST_R2_OFFSET = 8'h00;
  localparam logic [7:0] MOCR_RST_CONFIG_TWO = 8'h00;
  localparam logic [7:0] MOCR_RDATA_NONE = 8'h00;

  // Field positions in config_two
  localparam int MOCR_BIT_PRES_EN = 0;
  localparam int MOCR_BIT_FAN_ONE = 1;
  localparam int MOCR_BIT_FAN_TWO = 2;
  localparam int MOCR_BIT_FAN_THREE = 3;
  localparam int MOCR_BIT_AVG_OFF = 4;
  localparam int MOCR_BIT_DIV_BYP = 5;
  localparam int MOCR_BIT_SINGLE = 6;

  // Widths
  localparam int MOCR_FANS = 3;
  localparam int MOCR_VCH = 4;
  localparam int MOCR_TEMP_W = 10;
  localparam int MOCR_CODE_W = 4;

  // Converter channel codes
  localparam logic [3:0] MOCR_CH_FIRST = 4'h0;
  localparam logic [3:0] MOCR_CH_LAST = 4'h9;
  localparam logic [3:0] MOCR_CH_STEP = 4'h1;

  // Offset scaling: shift applied for each range setting
  localparam int MOCR_SHIFT_FINE = 1;
  localparam int MOCR_SHIFT_COARSE = 2;

  // Settings driven out to the measurement path
  typedef struct packed {
    logic fan_presence_detect_enable;
    logic measurement_averaging_off;
    logic [3:0] input_divider_bypass;
    logic single_channel_conversion;
  } mocr_ctrl_s;

  // Corrected remote-2 result
  typedef struct packed {
    logic valid;
    logic [9:0] temp;
  } mocr_temp_s;

endpackage : mocr_pkg

// File: logic/mocr_sync.sv
`timescale 1ns/1ps
module mocr_sync
  import mocr_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Asynchronous level in, filtered level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  // Refused at elaboration, before any logic is built
  if (W < 1) begin : g_bad_width
    $error("mocr_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } mocr_sync_s;

  mocr_sync_s st_q;
  mocr_sync_s st_d;

  // First stage is read only by the second stage
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.val;

endmodule : mocr_sync

// File: logic/mocr_regs.sv
// Notes on behaviour
// - Remote-2 offset is added to every remote-2 measurement before storing.
// - Offset range and resolution follow bit 1 of configuration five.
// - Lock bit set makes offset and config_two read-only; writes dropped.
// - Presence enable set makes bits 3..1 show four-wire fan presence.
// - Bits 1..3 read-only, each 1 when its fan has four wires.
// - Averaging-off bit turns averaging off, measurements about sixteen times faster.
// - Divider bypass bit bypasses attenuators on the four voltage inputs.
// - Each voltage attenuator also bypassable alone via configuration four bits.
// - Single-channel bit stops cycling and converts one selected input continuously.
// - Single-channel input comes from fan-one speed high byte bits 7..4.
`timescale 1ns/1ps
module mocr_regs
  import mocr_pkg::*;
#(
  parameter int TEMP_W = MOCR_TEMP_W,
  parameter int FANS = MOCR_FANS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port from the serial bus engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Settings held in neighbouring registers
  input wire logic config_lock,
  input wire logic offset_range_coarse,
  input wire logic [3:0] channel_divider_bypass,
  input wire logic [3:0] single_channel_select,
  // Fan presence sense pins
  input wire logic [2:0] fan_four_wire_sense,
  // Converter handshake
  input wire logic single_channel_conversion_done,
  output logic [3:0] single_channel_conversion_channel,
  // Remote-2 measurement in and corrected result out
  input wire logic remote2_raw_valid,
  input wire logic [9:0] remote2_raw_temp,
  output mocr_temp_s remote2_result,
  // Settings to the measurement path
  output mocr_ctrl_s ctrl
);

  // Saturation limits and field map assume these sizes
  if (TEMP_W != MOCR_TEMP_W) begin : g_bad_temp_w
    $error("mocr_regs: TEMP_W other than 10 not supported");
  end
  if (FANS != MOCR_FANS) begin : g_bad_fans
    $error("mocr_regs: FANS other than 3 not supported");
  end

  typedef struct packed {
    logic [7:0] offset;
    logic pres_en;
    logic [2:0] present;
    logic avg_off;
    logic div_byp;
    logic single;
    logic [3:0] channel;
    logic [7:0] rdata;
    logic rvalid;
    logic [9:0] temp;
    logic temp_valid;
  } mocr_regs_s;

  localparam logic [10:0] SAT_MAX = 11'h1ff;
  localparam logic [10:0] SAT_MIN = 11'h600;
  localparam logic [9:0] TEMP_MAX = 10'h1ff;
  localparam logic [9:0] TEMP_MIN = 10'h200;

  mocr_regs_s st_q;
  mocr_regs_s st_d;
  logic [2:0] sense_level;
  logic [9:0] offset_scaled;
  logic [10:0] temp_sum;
  logic [7:0] cfg_read;
  logic wr_ok;

  // Pins are asynchronous to ref_clk
  mocr_sync #(
    .W(MOCR_FANS)
  ) u_sense_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(fan_four_wire_sense),
    .level_out(sense_level)
  );

  // Lock blocks both registers at once
  assign wr_ok = reg_wr & ~config_lock;

  // Coarse range gives 1 degree steps, fine range half degree steps
  always_comb begin
    if (offset_range_coarse) begin
      offset_scaled = {st_q.offset, 2'b00};
    end else begin
      offset_scaled = {st_q.offset[7], st_q.offset, 1'b0};
    end
  end

  // Sign-extended add; saturate rather than wrap past full scale
  assign temp_sum = {remote2_raw_temp[9], remote2_raw_temp}
    + {offset_scaled[9], offset_scaled};

  // Read view of config_two
  always_comb begin
    cfg_read = MOCR_RST_CONFIG_TWO;
    cfg_read[MOCR_BIT_PRES_EN] = st_q.pres_en;
    cfg_read[MOCR_BIT_FAN_ONE] = st_q.present[0];
    cfg_read[MOCR_BIT_FAN_TWO] = st_q.present[1];
    cfg_read[MOCR_BIT_FAN_THREE] = st_q.present[2];
    cfg_read[MOCR_BIT_AVG_OFF] = st_q.avg_off;
    cfg_read[MOCR_BIT_DIV_BYP] = st_q.div_byp;
    cfg_read[MOCR_BIT_SINGLE] = st_q.single;
  end

  always_comb begin
    st_d = st_q;

    // Register writes
    if (wr_ok && reg_addr == MOCR_ADDR_R2_OFFSET) begin
      st_d.offset = reg_wdata;
    end
    if (wr_ok && reg_addr == MOCR_ADDR_CONFIG_TWO) begin
      st_d.pres_en = reg_wdata[MOCR_BIT_PRES_EN];
      st_d.avg_off = reg_wdata[MOCR_BIT_AVG_OFF];
      st_d.div_byp = reg_wdata[MOCR_BIT_DIV_BYP];
      st_d.single = reg_wdata[MOCR_BIT_SINGLE];
    end

    // Presence bits ignore writes; they read zero while detection is off
    if (st_q.pres_en) begin
      st_d.present = sense_level;
    end else begin
      st_d.present = '0;
    end

    // Read data one cycle after the strobe
    st_d.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        MOCR_ADDR_R2_OFFSET: begin
          st_d.rdata = st_q.offset;
        end
        MOCR_ADDR_CONFIG_TWO: begin
          st_d.rdata = cfg_read;
        end
        default: begin
          st_d.rdata = MOCR_RDATA_NONE;
        end
      endcase
    end

    // Converter channel sequencing
    if (st_q.single) begin
      st_d.channel = single_channel_select;
    end else if (single_channel_conversion_done) begin
      if (st_q.channel >= MOCR_CH_LAST) begin
        st_d.channel = MOCR_CH_FIRST;
      end else begin
        st_d.channel = st_q.channel + MOCR_CH_STEP;
      end
    end

    // Corrected remote-2 result
    st_d.temp_valid = remote2_raw_valid;
    if (remote2_raw_valid) begin
      if ($signed(temp_sum) > $signed(SAT_MAX)) begin
        st_d.temp = TEMP_MAX;
      end else if ($signed(temp_sum) < $signed(SAT_MIN)) begin
        st_d.temp = TEMP_MIN;
      end else begin
        st_d.temp = temp_sum[9:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q.offset <= MOCR_RST_R2_OFFSET;
      st_q.pres_en <= MOCR_RST_CONFIG_TWO[MOCR_BIT_PRES_EN];
      st_q.present <= '0;
      st_q.avg_off <= MOCR_RST_CONFIG_TWO[MOCR_BIT_AVG_OFF];
      st_q.div_byp <= MOCR_RST_CONFIG_TWO[MOCR_BIT_DIV_BYP];
      st_q.single <= MOCR_RST_CONFIG_TWO[MOCR_BIT_SINGLE];
      st_q.channel <= MOCR_CH_FIRST;
      st_q.rdata <= MOCR_RDATA_NONE;
      st_q.rvalid <= 1'b0;
      st_q.temp <= '0;
      st_q.temp_valid <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign single_channel_conversion_channel = st_q.channel;
  assign remote2_result.valid = st_q.temp_valid;
  assign remote2_result.temp = st_q.temp;
  assign ctrl.fan_presence_detect_enable = st_q.pres_en;
  // Averaging count itself lives in the converter
  assign ctrl.measurement_averaging_off = st_q.avg_off;
  // Global bypass or per-channel bypass, either suffices
  assign ctrl.input_divider_bypass =
    {MOCR_VCH{st_q.div_byp}} | channel_divider_bypass;
  assign ctrl.single_channel_conversion = st_q.single;

endmodule : mocr_regs

// File: verif/mocr_host.sv
`timescale 1ns/1ps
module mocr_host (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Idle lines flip so stale values are never mistaken for live ones
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask : rd
endmodule : mocr_host

// File: verif/mocr_regs_sva.sv
`timescale 1ns/1ps
module mocr_regs_sva
  import mocr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic config_lock,
  input wire logic [3:0] channel_divider_bypass,
  input wire logic [3:0] single_channel_select,
  input wire logic single_channel_conversion_done,
  input wire logic [3:0] single_channel_conversion_channel,
  input wire logic remote2_raw_valid,
  input wire mocr_temp_s remote2_result,
  input wire mocr_ctrl_s ctrl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic cw;
  assign cw = reg_wr && !config_lock && reg_addr == MOCR_ADDR_CONFIG_TWO;
  pres_en_a: assert property (
    cw |=> ctrl.fan_presence_detect_enable == $past(reg_wdata[0]))
    else $error("presence enable not written");
  avg_off_a: assert property (
    cw |=> ctrl.measurement_averaging_off == $past(reg_wdata[4]))
    else $error("averaging bit not written");
  single_en_a: assert property (
    cw |=> ctrl.single_channel_conversion == $past(reg_wdata[6]))
    else $error("single mode bit not written");
  div_byp_a: assert property (
    cw |=> ctrl.input_divider_bypass ==
      ({4{$past(reg_wdata[5])}} | channel_divider_bypass))
    else $error("divider bypass wrong");
  lock_hold_a: assert property (
    reg_wr && config_lock |=> $stable(ctrl))
    else $error("locked write took effect");
  temp_valid_a: assert property (
    remote2_raw_valid |=> remote2_result.valid)
    else $error("corrected sample missing");
  single_channel_conversion_step_a: assert property (
    single_channel_conversion_done && !ctrl.single_channel_conversion |=> single_channel_conversion_channel ==
      ($past(single_channel_conversion_channel) == 4'h9 ? 4'h0 : $past(single_channel_conversion_channel) + 4'h1))
    else $error("round robin step wrong");
  single_follow_a: assert property (
    ctrl.single_channel_conversion |=>
      single_channel_conversion_channel == $past(single_channel_select))
    else $error("single channel not followed");
endmodule : mocr_regs_sva
bind mocr_regs mocr_regs_sva sva_u (
  .ref_clk(ref_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .config_lock(config_lock),
  .channel_divider_bypass(channel_divider_bypass),
  .single_channel_select(single_channel_select),
  .single_channel_conversion_done(single_channel_conversion_done),
  .single_channel_conversion_channel(single_channel_conversion_channel),
  .remote2_raw_valid(remote2_raw_valid),
  .remote2_result(remote2_result),
  .ctrl(ctrl)
);

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mocr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, o;
  logic reg_wr, reg_rd, reg_rvalid, config_lock, offset_range_coarse;
  logic single_channel_conversion_done, remote2_raw_valid;
  logic [3:0] channel_divider_bypass, single_channel_select, single_channel_conversion_channel;
  logic [2:0] fan_four_wire_sense;
  logic [9:0] remote2_raw_temp, r;
  mocr_temp_s remote2_result;
  mocr_ctrl_s ctrl;
  int error_cnt = 0;
  int compares = 0;
  integer seed = 32'hd181c292;
  always #12.5 ref_clk = ~ref_clk;
  mocr_host host_u (
    .ref_clk(ref_clk),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );
  mocr_regs dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .config_lock(config_lock),
    .offset_range_coarse(offset_range_coarse),
    .channel_divider_bypass(channel_divider_bypass),
    .single_channel_select(single_channel_select),
    .fan_four_wire_sense(fan_four_wire_sense),
    .single_channel_conversion_done(single_channel_conversion_done),
    .single_channel_conversion_channel(single_channel_conversion_channel),
    .remote2_raw_valid(remote2_raw_valid),
    .remote2_raw_temp(remote2_raw_temp),
    .remote2_result(remote2_result),
    .ctrl(ctrl)
  );
  task chk(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rv);
    chk({2'h0, rv}, {2'h0, e});
  endtask : rchk
  function automatic logic [9:0] sat(logic [9:0] t, logic [7:0] f, logic c);
    int s;
    s = $signed(t) + $signed(f) * (c ? 4 : 2);
    if (s > 511) s = 511;
    if (s < -512) s = -512;
    return s[9:0];
  endfunction : sat
  task summarize;
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Roughly twenty times the expected run
  initial begin
    #(25 * 5000);
    error_cnt++;
    summarize();
  end
  initial begin
    {config_lock, offset_range_coarse, single_channel_conversion_done, remote2_raw_valid} = 4'h0;
    {channel_divider_bypass, single_channel_select} = 8'h00;
    fan_four_wire_sense = 3'h0;
    remote2_raw_temp = 10'h000;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    rchk(MOCR_ADDR_R2_OFFSET, MOCR_RST_R2_OFFSET);
    rchk(MOCR_ADDR_CONFIG_TWO, MOCR_RST_CONFIG_TWO);
    repeat (11) begin
      @(negedge ref_clk) single_channel_conversion_done = 1'b1;
      @(negedge ref_clk) single_channel_conversion_done = 1'b0;
    end
    chk(10'(single_channel_conversion_channel), 10'h1);
    host_u.wr(MOCR_ADDR_CONFIG_TWO, 8'h40);
    for (int k = 0; k < 10; k++) begin
      single_channel_select = 4'(k);
      single_channel_conversion_done = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(10'(single_channel_conversion_channel), 10'(k));
    end
    single_channel_conversion_done = 1'b0;
    host_u.wr(MOCR_ADDR_CONFIG_TWO, 8'h00);
    @(negedge ref_clk) single_channel_conversion_done = 1'b1;
    @(negedge ref_clk) single_channel_conversion_done = 1'b0;
    chk(10'(single_channel_conversion_channel), 10'h0);
    host_u.wr(MOCR_ADDR_CONFIG_TWO, 8'hff);
    rchk(MOCR_ADDR_CONFIG_TWO, 8'h71);
    fan_four_wire_sense = 3'b101;
    repeat (8) @(negedge ref_clk);
    rchk(MOCR_ADDR_CONFIG_TWO, 8'h7b);
    host_u.wr(MOCR_ADDR_CONFIG_TWO, 8'h20);
    channel_divider_bypass = 4'h5;
    rchk(MOCR_ADDR_CONFIG_TWO, 8'h20);
    chk(10'(ctrl.input_divider_bypass), 10'hf);
    host_u.wr(MOCR_ADDR_CONFIG_TWO, 8'h00);
    chk(10'(ctrl.input_divider_bypass), 10'h5);
    host_u.wr(MOCR_ADDR_R2_OFFSET, 8'h3c);
    config_lock = 1'b1;
    host_u.wr(MOCR_ADDR_R2_OFFSET, 8'hc3);
    host_u.wr(MOCR_ADDR_CONFIG_TWO, 8'h50);
    rchk(MOCR_ADDR_R2_OFFSET, 8'h3c);
    rchk(MOCR_ADDR_CONFIG_TWO, 8'h00);
    config_lock = 1'b0;
    host_u.wr(8'h74, 8'h11);
    rchk(8'h74, MOCR_RDATA_NONE);
    for (int k = 0; k < 24; k++) begin
      o = k < 2 ? (k == 1 ? 8'h80 : 8'h7f) : 8'($random(seed));
      r = k < 2 ? (k == 1 ? 10'h200 : 10'h1ff) : 10'($random(seed));
      offset_range_coarse = 1'($random(seed));
      host_u.wr(MOCR_ADDR_R2_OFFSET, o);
      rchk(MOCR_ADDR_R2_OFFSET, o);
      remote2_raw_temp = r;
      remote2_raw_valid = 1'b1;
      @(negedge ref_clk) remote2_raw_valid = 1'b0;
      remote2_raw_temp = ~r;
      chk({9'h0, remote2_result.valid}, 10'h1);
      chk(remote2_result.temp, sat(r, o, offset_range_coarse));
    end
    summarize();
  end
endmodule : tb_top
